// ===== design/hbridge_pkg.sv
package hbridge_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_MHZ = 250;
  // speed threshold between input edges, in microseconds
  localparam int unsigned SPEED_THRESH_US = 250;
  localparam int unsigned SPEED_THRESH_CYC = SPEED_THRESH_US * CLK_MHZ;
  // low-side blanking time, in nanoseconds (3.0 us)
  localparam int unsigned BLANK_NS = 3000;
  localparam int unsigned BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic SPEED_HIGH_RST = 1'b0;
  localparam logic FAULT_N_RST = 1'b1;

endpackage : hbridge_pkg

// ===== design/hbridge_protect_speed_ctrl.sv
`timescale 1ns/1ps

module hbridge_protect_speed_ctrl #(
  parameter int unsigned SPEED_THRESH_CYC = hbridge_pkg::SPEED_THRESH_CYC,
  parameter int unsigned BLANK_CYC = hbridge_pkg::BLANK_CYC
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic wake,
  input wire logic channel_a_input,
  input wire logic channel_b_input,
  input wire logic [1:0] overtemp_det,
  input wire logic [1:0] hs_overcurrent_det,
  input wire logic [1:0] output_below_2v,
  input wire logic [1:0] ls_overload_det,
  output logic [1:0] hs_on,
  output logic [1:0] hs_out_en,
  output logic [1:0] lowside_gate,
  output logic [1:0] speed_high,
  output logic fault_flag_n
);

  // the interval timer stops one count past its limit and the blanking timer at its limit, so a long pause can never wrap
  // round into a false short interval or a false overload
  localparam int CW = $clog2(SPEED_THRESH_CYC + 2);
  localparam int BW = $clog2(BLANK_CYC + 2);

  // the whole block state, registered in one place
  typedef struct packed {
    logic [1:0] in_prev;
    logic [1:0][CW-1:0] ivl_cnt;
    logic [1:0] speed_high;
    logic [1:0] hs_oc_latch;
    logic [1:0] hs_oc_seen_low;
    logic [1:0][BW-1:0] blank_cnt;
    logic [1:0] ls_oc_latch;
    logic [1:0] ls_oc_armed;
    logic [1:0] hs_on;
    logic [1:0] hs_out_en;
    logic [1:0] lowside_gate;
    logic fault_n;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [1:0] in_now;

  // bit 0 is channel a and bit 1 channel b in every vector
  assign in_now = {channel_b_input, channel_a_input};

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb
  begin
    logic ot_any;
    logic ls_trip;
    logic ls_any;
    logic [1:0] edge_seen;
    ot_any = 1'b0;
    ls_trip = 1'b0;
    ls_any = 1'b0;
    edge_seen = in_now ^ state_reg.in_prev;
    state_next = state_reg;
    state_next.in_prev = in_now;
    for (int i = 0; i < 2; i++)
    begin
      if (edge_seen[i])
      begin
        // long interval, slow mode
        // the count equals the interval in cycles; an exact match is slow
        state_next.speed_high[i] = (state_reg.ivl_cnt[i] < CW'(SPEED_THRESH_CYC));
        state_next.ivl_cnt[i] = CW'(1);
      end
      else if (state_reg.ivl_cnt[i] <= CW'(SPEED_THRESH_CYC))
        state_next.ivl_cnt[i] = state_reg.ivl_cnt[i] + CW'(1);
      // sense only while conducting
      // sensing stops once the high sides are off, so a held overtemperature
      // makes the high side chatter; the sensor hysteresis is relied on
      if (state_reg.hs_on[i] && overtemp_det[i])
        ot_any = 1'b1;
      // latch high-side overcurrent
      // a fresh trip wins over a release falling in the same cycle
      if (state_reg.hs_on[i] && hs_overcurrent_det[i])
      begin
        state_next.hs_oc_latch[i] = 1'b1;
        state_next.hs_oc_seen_low[i] = 1'b0;
      end
      else if (state_reg.hs_oc_latch[i])
      begin
        if (!in_now[i])
          state_next.hs_oc_seen_low[i] = 1'b1;
        else if (state_reg.hs_oc_seen_low[i] && !state_reg.in_prev[i])
          state_next.hs_oc_latch[i] = 1'b0;
      end
      // blanking filter on low-side overload
      // the counter stops at its limit; any gap in the overload restarts it
      if (state_reg.lowside_gate[i] && ls_overload_det[i])
      begin
        if (state_reg.blank_cnt[i] < BW'(BLANK_CYC))
          state_next.blank_cnt[i] = state_reg.blank_cnt[i] + BW'(1);
      end
      else
        state_next.blank_cnt[i] = '0;
      if (state_reg.blank_cnt[i] >= BW'(BLANK_CYC - 1) && ls_overload_det[i] &&
          state_reg.lowside_gate[i])
      begin
        ls_trip = 1'b1;
        state_next.ls_oc_latch[i] = 1'b1;
        state_next.ls_oc_armed[i] = 1'b0;
      end
      else if (state_reg.ls_oc_latch[i])
      begin
        // faulted input toggle releases
        // the first clean edge arms, the second one releases
        if (!ls_overload_det[i] && edge_seen[i])
        begin
          if (state_reg.ls_oc_armed[i])
            state_next.ls_oc_latch[i] = 1'b0;
          else
            state_next.ls_oc_armed[i] = 1'b1;
        end
      end
    end
    // a trip in this cycle opens the bridge on the very next edge
    ls_any = ls_trip | (|state_reg.ls_oc_latch);
    // later overrides win: sleep beats every fault, a fault beats the inputs
    for (int i = 0; i < 2; i++)
    begin
      // input steers high side and gate
      state_next.hs_on[i] = in_now[i];
      state_next.hs_out_en[i] = 1'b1;
      // gate only with node below 2.0 V
      state_next.lowside_gate[i] = !in_now[i] && output_below_2v[i];
      // follows inputs once cleared
      // overtemperature is not latched, so no controller action is needed
      if (ot_any)
      begin
        state_next.hs_on[i] = 1'b0;
        state_next.lowside_gate[i] = output_below_2v[i];
      end
      if (state_next.hs_oc_latch[i])
      begin
        state_next.hs_on[i] = 1'b0;
        state_next.hs_out_en[i] = 1'b0;
        state_next.lowside_gate[i] = 1'b0;
      end
      if (ls_any)
      begin
        state_next.hs_on[i] = 1'b0;
        state_next.hs_out_en[i] = 1'b0;
        state_next.lowside_gate[i] = 1'b0;
      end
      if (!wake)
      begin
        state_next.hs_on[i] = 1'b0;
        state_next.hs_out_en[i] = 1'b0;
        state_next.lowside_gate[i] = 1'b0;
      end
    end
    state_next.fault_n = wake ? !(ot_any | (|state_next.hs_oc_latch) | ls_any) : 1'b1;
    // sleep forgets every latched fault, much like a power cycle
    if (!wake)
    begin
      state_next.hs_oc_latch = '0;
      state_next.ls_oc_latch = '0;
      state_next.blank_cnt = '0;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  // reset leaves the bridge open and the fault flag released
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= '0;
      state_reg.speed_high <= {2{hbridge_pkg::SPEED_HIGH_RST}};
      state_reg.fault_n <= hbridge_pkg::FAULT_N_RST;
    end
    else
      state_reg <= state_next;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // every output is taken straight from the state register
  assign hs_on = state_reg.hs_on;
  assign hs_out_en = state_reg.hs_out_en;
  assign lowside_gate = state_reg.lowside_gate;
  assign speed_high = state_reg.speed_high;
  assign fault_flag_n = state_reg.fault_n;

endmodule : hbridge_protect_speed_ctrl

// ===== test/hbridge_asserts.sv
`timescale 1ns/1ps
// ****
// protection checks
// ****
module hbridge_asserts (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic wake,
  input wire logic channel_a_input,
  input wire logic [1:0] overtemp_det,
  input wire logic [1:0] hs_overcurrent_det,
  input wire logic [1:0] ls_overload_det,
  input wire logic [1:0] output_below_2v,
  input wire logic [1:0] hs_on,
  input wire logic [1:0] hs_out_en,
  input wire logic [1:0] lowside_gate,
  input wire logic [1:0] speed_high,
  input wire logic fault_flag_n
);
  // outputs follow the inputs of the edge before, so one clock covers all
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  a_sleep_open: assert property (!wake |=> hs_on == 2'h0 && hs_out_en == 2'h0
    && lowside_gate == 2'h0 && fault_flag_n) else $error("sleep");
  a_gate_interlock: assert property (lowside_gate[0] |-> $past(output_below_2v[0]))
    else $error("interlock");
  a_high_drive: assert property (hs_on[0] |-> $past(channel_a_input) && !lowside_gate[0])
    else $error("drive");
  a_hs_trip: assert property (wake && hs_on[0] && hs_overcurrent_det[0] |=>
    !hs_out_en[0] && !fault_flag_n) else $error("hs trip");
  a_otemp_off: assert property (wake && hs_on[0] && overtemp_det[0] |=>
    hs_on == 2'h0 && !fault_flag_n) else $error("overtemp");
  a_otemp_gated: assert property (wake && hs_on == 2'h0 && hs_out_en == 2'h3
    && fault_flag_n && hs_overcurrent_det == 2'h0 && ls_overload_det == 2'h0
    |=> fault_flag_n) else $error("gated");
  // the repeat count matches the short blanking time used by the bench
  a_ls_trip: assert property ((wake && lowside_gate[0] && ls_overload_det[0])[*4]
    |-> ##[1:2] hs_out_en == 2'h0 && !fault_flag_n) else $error("ls trip");
  // the edge seen right after reset compares against the cleared history
  a_speed_edge: assert property ($changed(speed_high[0]) && $past(arst_n, 2) |->
    $past(channel_a_input) != $past(channel_a_input, 2)) else $error("speed");
endmodule : hbridge_asserts

bind hbridge_protect_speed_ctrl hbridge_asserts chk (.clk_sys, .arst_n, .wake,
  .channel_a_input, .overtemp_det, .hs_overcurrent_det, .ls_overload_det,
  .output_below_2v, .hs_on, .hs_out_en, .lowside_gate, .speed_high, .fault_flag_n);

// ===== test/mcu_model.sv
`timescale 1ns/1ps
// controller: level commands, periodic toggling of a, input reset
module mcu_model (
  input wire logic clk_sys,
  input wire logic [1:0] cmd,
  input wire logic [7:0] half,
  input wire logic clear,
  output logic channel_a_input,
  output logic channel_b_input
);
  int n = 0;
  // drive just after each edge so the design samples settled levels
  initial
  begin
    {channel_b_input, channel_a_input} = 2'h0;
    forever
    begin
      @(posedge clk_sys);
      #1;
      n++;
      if (clear)
        {channel_b_input, channel_a_input} = 2'h0;
      else if (half == 8'h00)
        {channel_b_input, channel_a_input} = cmd;
      else if (n >= half)
      begin
        channel_a_input = ~channel_a_input;
        n = 0;
      end
    end
  end
endmodule : mcu_model

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'h0, arst_n = 1'h0, wake = 1'h0, clear = 1'h0, a, b, fault_n;
  logic [1:0] cmd = 2'h0, ot = 2'h0, oc = 2'h0, lso = 2'h0, b2v = 2'h3;
  logic [1:0] hs_on, hs_out_en, gate, spd;
  logic [7:0] half = 8'h00;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  // short interval threshold and blanking time keep the run brief
  localparam int SPEED_TB = 20;
  localparam int BLANK_TB = 4;
  // rows: wake, inputs, below 2 V, then hs_on, gates, fault flag
  logic [9:0] rows [6] = '{10'h1E1, 10'h201, 10'h267, 10'h2ED, 10'h373, 10'h3F9};
  mcu_model mcu (.clk_sys, .cmd, .half, .clear, .channel_a_input(a), .channel_b_input(b));
  hbridge_protect_speed_ctrl #(.SPEED_THRESH_CYC(SPEED_TB), .BLANK_CYC(BLANK_TB)) dut (
    .clk_sys, .arst_n, .wake, .channel_a_input(a), .channel_b_input(b), .overtemp_det(ot),
    .hs_overcurrent_det(oc), .output_below_2v(b2v), .ls_overload_det(lso), .hs_on,
    .hs_out_en, .lowside_gate(gate), .speed_high(spd), .fault_flag_n(fault_n));
  initial
    forever #2 clk_sys = ~clk_sys;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    if (fail_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  // table first, then speed, high-side latch, overtemperature, low-side latch and reset by hand
  initial
  begin
    tick(16);
    arst_n = 1'h1;
    foreach (rows[i])
    begin
      {wake, cmd, b2v} = rows[i][9:5];
      tick(3);
      chk({hs_on, gate, fault_n}, rows[i][4:0]);
    end
    // channel b stands still, so its mode keeps its last short interval
    half = 8'h05;
    tick(80);
    chk({3'h0, spd}, 5'h03);
    half = 8'(SPEED_TB - 1);
    tick(60);
    chk({3'h0, spd}, 5'h03);
    half = 8'(SPEED_TB);
    tick(70);
    chk({3'h0, spd}, 5'h02);
    half = 8'h1E;
    tick(120);
    chk({3'h0, spd}, 5'h02);
    half = 8'h00;
    cmd = 2'h1;
    tick(3);
    oc = 2'h1;
    tick(1);
    oc = 2'h0;
    chk({hs_out_en, gate, fault_n}, 5'h14);
    tick(3);
    chk({hs_out_en, gate, fault_n}, 5'h14);
    clear = 1'h1;
    tick(2);
    clear = 1'h0;
    tick(4);
    chk({hs_on, gate, fault_n}, 5'h0D);
    ot = 2'h1;
    tick(1);
    chk({hs_on, gate, fault_n}, 5'h06);
    ot = 2'h0;
    tick(3);
    chk({hs_on, gate, fault_n}, 5'h0D);
    cmd = 2'h0;
    tick(3);
    // heat with both high sides off must go unnoticed
    ot = 2'h3;
    tick(3);
    chk({hs_on, gate, fault_n}, 5'h07);
    ot = 2'h0;
    lso = 2'h1;
    // bounded wait; running out shows up as a wrong cycle count
    while (cyc < 20 && fault_n !== 1'h0)
    begin
      tick(1);
      cyc++;
    end
    chk(5'(cyc), 5'(BLANK_TB));
    lso = 2'h0;
    tick(3);
    chk({hs_out_en, gate, fault_n}, 5'h00);
    cmd = 2'h1;
    tick(3);
    chk({hs_out_en, gate, fault_n}, 5'h00);
    clear = 1'h1;
    tick(2);
    clear = 1'h0;
    tick(4);
    chk({hs_out_en, gate, fault_n}, 5'h1D);
    arst_n = 1'h0;
    tick(1);
    chk({hs_out_en, spd, fault_n}, 5'h01);
    arst_n = 1'h1;
    tick(3);
    chk({hs_on, gate, fault_n}, 5'h0D);
    end_sim();
  end
endmodule : tb_top
